/* File: hw/ubu_core.sv */
// USB serial UART core: FIFOs, baud generator, UART, bit-bang, pin mux
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps

// ============================================================
// Byte FIFO with count
module ubu_fifo #(
  parameter int W = 8,
  parameter int AW = 9
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic push_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic pop_i,
  output logic [W-1:0] rdata_o,
  output logic full_o,
  output logic empty_o,
  output logic [AW:0] count_o
);
  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  wire do_push = push_i & ~full_o;
  wire do_pop = pop_i & ~empty_o;

  assign full_o = cnt_r[AW];
  assign empty_o = (cnt_r == '0);
  assign count_o = cnt_r;
  assign rdata_o = mem[rd_ptr_r];

  // Storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr_r] <= wdata_i;
    end
  end

  // Pointers and level
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(do_push);
      rd_ptr_r <= rd_ptr_r + AW'(do_pop);
      cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// ============================================================
// Top of the serial side
module ubu_core (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [3:0] ser_pin_i,
  output logic [3:0] ser_pin_o,
  output logic [3:0] ser_pin_oe_o,
  output logic config_pin_o,
  output logic config_pin_oe_o,
  input wire logic suspend_i
);
  // ==========================================================
  // Pin synchronisers
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_r <= 4'hF; // Idle lines read high, no false start
      pin_s2_r <= 4'hF;
    end else begin
      pin_s1_r <= ser_pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ==========================================================
  // Register state and field decode
  logic [15:0] ctrl_r;
  logic [16:0] baud_r;
  logic [7:0] nvcfg_r;
  logic [3:0] sticky_r;
  logic wait_r;
  wire [1:0] mode = ctrl_r[ubu_pkg::CTRL_MODE_LSB +: 2];
  wire data8 = ctrl_r[ubu_pkg::CTRL_DATA8];
  wire [2:0] par_mode = ctrl_r[ubu_pkg::CTRL_PAR_LSB +: 3];
  wire stop2 = ctrl_r[ubu_pkg::CTRL_STOP2];
  wire [1:0] flow = ctrl_r[ubu_pkg::CTRL_FLOW_LSB +: 2];
  wire brk_cmd = ctrl_r[ubu_pkg::CTRL_BREAK];
  wire [3:0] bb_dir = ctrl_r[ubu_pkg::CTRL_DIR_LSB +: 4];
  wire [3:0] pin_func = nvcfg_r[3:0];
  wire [3:0] inv = nvcfg_r[ubu_pkg::NVCFG_INV_LSB +: 4];
  wire uart_mode = (mode == ubu_pkg::MODE_UART);

  // Bus handshake decode
  wire req = avs_read_i | avs_write_i;
  wire take = req & ~wait_r;
  wire wr = take & avs_write_i;
  wire rd = take & avs_read_i;
  wire [4:0] addr = {avs_address_i[4:2], 2'b00};
  wire [31:0] wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                       {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wbits = avs_writedata_i & wmask;
  wire wr_ctrl = wr & (addr == ubu_pkg::REG_CTRL);
  wire wr_baud = wr & (addr == ubu_pkg::REG_BAUD);
  wire wr_nvcfg = wr & (addr == ubu_pkg::REG_NVCFG);
  wire wr_data = wr & (addr == ubu_pkg::REG_DATA) & avs_byteenable_i[0];
  wire wr_status = wr & (addr == ubu_pkg::REG_STATUS);
  wire rd_data = rd & (addr == ubu_pkg::REG_DATA);
  wire rd_pins = rd & (addr == ubu_pkg::REG_PINS);

  // ==========================================================
  // FIFOs: host OUT bytes to line, line bytes to host IN
  logic out_pop;
  logic [7:0] out_head;
  logic out_full;
  logic out_empty;
  logic [9:0] out_cnt;
  logic in_push;
  logic [7:0] in_wdata;
  logic [7:0] in_head;
  logic in_full;
  logic in_empty;
  logic [9:0] in_cnt;

  ubu_fifo #(.W(8), .AW(9)) u_out_fifo (
    .clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .push_i(wr_data), .wdata_i(avs_writedata_i[7:0]),
    .pop_i(out_pop), .rdata_o(out_head),
    .full_o(out_full), .empty_o(out_empty), .count_o(out_cnt));

  ubu_fifo #(.W(8), .AW(9)) u_in_fifo (
    .clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .push_i(in_push), .wdata_i(in_wdata),
    .pop_i(rd_data), .rdata_o(in_head),
    .full_o(in_full), .empty_o(in_empty), .count_o(in_cnt));

  // ==========================================================
  // Reference clock phase: bits give 24, 12 and 6 MHz
  logic [18:0] ref_acc_r;
  logic ref12_prev_r;
  wire osc12_tick = ref_acc_r[ubu_pkg::REF_BIT_12M] & ~ref12_prev_r;

  // Sixteen-times baud tick from the 48 MHz reference
  logic [20:0] baud_acc_r;
  logic tick16_r;
  wire [13:0] n_raw = baud_r[13:0];
  wire [2:0] x_raw = baud_r[ubu_pkg::BAUD_FRAC_LSB +: 3];
  wire [14:0] n_eff = (n_raw == ubu_pkg::BAUD_N_MAX_CODE) ?
                      ubu_pkg::BAUD_N_MAX : {1'b0, n_raw};
  wire [2:0] x_eff = (n_raw == 14'h0001) ? 3'h0 : x_raw;
  wire [17:0] div8 = {n_eff, x_eff};
  wire [20:0] thr = 21'(div8 * ubu_pkg::BAUD_SCALE);
  wire [21:0] acc_sum = {1'b0, baud_acc_r} + ubu_pkg::BAUD_INC;
  wire baud_hit = (acc_sum >= {1'b0, thr});

  // Power-on and pin reset arrive merged on rst_b_i
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_acc_r <= 19'h00000;
      ref12_prev_r <= 1'b0;
      baud_acc_r <= 21'h000000;
      tick16_r <= 1'b0;
    end else begin
      ref_acc_r <= ref_acc_r + ubu_pkg::REF_PHASE_INC;
      ref12_prev_r <= ref_acc_r[ubu_pkg::REF_BIT_12M];
      baud_acc_r <= baud_hit ? 21'(acc_sum - {1'b0, thr}) : acc_sum[20:0];
      tick16_r <= baud_hit;
    end
  end

  // ==========================================================
  // Transmitter
  ubu_pkg::ubu_tx_e tx_st_r;
  logic [3:0] tx_sub_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic tx_par_r;
  logic tx_stop_r;
  logic paused_r;
  wire cts_ok = ~(pin_s2_r[3] ^ inv[3]);
  wire [2:0] last_bit = data8 ? 3'h7 : 3'h6;
  wire [7:0] out_dm = data8 ? out_head : {1'b0, out_head[6:0]};
  wire flow_ok = ~paused_r &
    ((flow != ubu_pkg::FLOW_RTSCTS) | cts_ok);
  wire tx_load = uart_mode & osc12_tick & ~out_empty &
    flow_ok & (tx_st_r == ubu_pkg::TX_IDLE);
  wire tx_end = tick16_r & (tx_sub_r == ubu_pkg::SUB_LAST);
  wire par_calc = (par_mode == ubu_pkg::PAR_ODD) ? ~^out_dm :
                  (par_mode == ubu_pkg::PAR_EVEN) ? ^out_dm :
                  (par_mode == ubu_pkg::PAR_MARK);
  wire tx_line = (tx_st_r == ubu_pkg::TX_START) ? 1'b0 :
                 (tx_st_r == ubu_pkg::TX_DATA) ? tx_sh_r[0] :
                 (tx_st_r == ubu_pkg::TX_PAR) ? tx_par_r : 1'b1;
  wire tx_busy = (tx_st_r != ubu_pkg::TX_IDLE);

  // Frame sequencer, one bit per sixteen ticks
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_st_r <= ubu_pkg::TX_IDLE;
      tx_sub_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_par_r <= 1'b0;
      tx_stop_r <= 1'b0;
    end else begin
      if (tick16_r) begin
        tx_sub_r <= tx_sub_r + 4'h1;
      end
      case (tx_st_r)
        ubu_pkg::TX_IDLE: begin
          if (tx_load) begin
            tx_st_r <= ubu_pkg::TX_START;
            tx_sh_r <= out_dm;
            tx_par_r <= par_calc;
            tx_sub_r <= 4'h0;
          end
        end
        ubu_pkg::TX_START: begin
          if (tx_end) begin
            tx_st_r <= ubu_pkg::TX_DATA;
            tx_bit_r <= 3'h0;
          end
        end
        ubu_pkg::TX_DATA: begin
          if (tx_end) begin
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            tx_bit_r <= tx_bit_r + 3'h1;
            tx_stop_r <= 1'b0;
            if (tx_bit_r == last_bit) begin
              tx_st_r <= (par_mode == ubu_pkg::PAR_NONE) ?
                ubu_pkg::TX_STOP : ubu_pkg::TX_PAR;
            end
          end
        end
        ubu_pkg::TX_PAR: begin
          if (tx_end) begin
            tx_st_r <= ubu_pkg::TX_STOP;
          end
        end
        ubu_pkg::TX_STOP: begin
          if (tx_end) begin
            tx_stop_r <= 1'b1;
            if (!stop2 || tx_stop_r) begin
              tx_st_r <= ubu_pkg::TX_IDLE;
            end
          end
        end
        default: tx_st_r <= ubu_pkg::TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Receiver
  ubu_pkg::ubu_rx_e rx_st_r;
  logic [3:0] rx_sub_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_par_r;
  logic rx_push_r;
  logic [7:0] rx_byte_r;
  wire rx_line = pin_s2_r[1] ^ inv[1];
  wire rx_end = tick16_r & (rx_sub_r == ubu_pkg::SUB_LAST);
  wire [7:0] rx_data = data8 ? rx_sh_r : {1'b0, rx_sh_r[7:1]};
  wire rx_par_exp = (par_mode == ubu_pkg::PAR_ODD) ? ~^rx_data :
                    (par_mode == ubu_pkg::PAR_EVEN) ? ^rx_data :
                    (par_mode == ubu_pkg::PAR_MARK);
  wire rx_stop_ev = (rx_st_r == ubu_pkg::RX_STOP) & rx_end;
  wire rx_brk = rx_stop_ev & ~rx_line & (rx_data == 8'h00) & ~rx_par_r;
  wire rx_ferr = rx_stop_ev & ~rx_line & ~rx_brk;
  wire rx_good = rx_stop_ev & rx_line;
  wire rx_perr = rx_good & (par_mode != ubu_pkg::PAR_NONE) &
    (rx_par_r != rx_par_exp);
  wire xon_on = (flow == ubu_pkg::FLOW_XONXOFF);
  wire rx_xoff = rx_good & xon_on & (rx_data == ubu_pkg::CHAR_XOFF);
  wire rx_xon = rx_good & xon_on & (rx_data == ubu_pkg::CHAR_XON);

  // Start found mid-bit, then one sample per sixteen ticks
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_st_r <= ubu_pkg::RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
    end else begin
      if (tick16_r) begin
        rx_sub_r <= rx_sub_r + 4'h1;
      end
      case (rx_st_r)
        ubu_pkg::RX_IDLE: begin
          if (uart_mode && tick16_r && !rx_line) begin
            rx_st_r <= ubu_pkg::RX_START;
            rx_sub_r <= 4'h0;
          end
        end
        ubu_pkg::RX_START: begin
          if (tick16_r && rx_sub_r == ubu_pkg::SUB_MID) begin
            rx_st_r <= rx_line ? ubu_pkg::RX_IDLE : ubu_pkg::RX_DATA;
            rx_sub_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_par_r <= 1'b0;
          end
        end
        ubu_pkg::RX_DATA: begin
          if (rx_end) begin
            rx_sh_r <= {rx_line, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == last_bit) begin
              rx_st_r <= (par_mode == ubu_pkg::PAR_NONE) ?
                ubu_pkg::RX_STOP : ubu_pkg::RX_PAR;
            end
          end
        end
        ubu_pkg::RX_PAR: begin
          if (rx_end) begin
            rx_par_r <= rx_line;
            rx_st_r <= ubu_pkg::RX_STOP;
          end
        end
        ubu_pkg::RX_STOP: begin
          if (rx_end) begin
            rx_st_r <= rx_line ? ubu_pkg::RX_IDLE : ubu_pkg::RX_WAIT;
          end
        end
        ubu_pkg::RX_WAIT: begin
          if (rx_line) begin // Hold off until the line idles again
            rx_st_r <= ubu_pkg::RX_IDLE;
          end
        end
        default: rx_st_r <= ubu_pkg::RX_IDLE;
      endcase
    end
  end

  // Completed characters and pause state
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_push_r <= 1'b0;
      rx_byte_r <= 8'h00;
      paused_r <= 1'b0;
    end else begin
      rx_push_r <= rx_good & ~rx_xon & ~rx_xoff;
      rx_byte_r <= rx_data;
      if (!xon_on || rx_xon) begin
        paused_r <= 1'b0;
      end else if (rx_xoff) begin
        paused_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Bit-bang engine, one host byte per baud period
  logic [3:0] bb_sub_r;
  logic [3:0] bb_out_r;
  logic bb_wr_n_r;
  logic bb_rd_n_r;
  logic bb_samp_r;
  logic [3:0] bb_in_r;
  wire bb_step = ~uart_mode & tick16_r &
    (bb_sub_r == ubu_pkg::SUB_LAST) & ~out_empty;
  wire sync_bb = (mode == ubu_pkg::MODE_BB_SYNC);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bb_sub_r <= 4'h0;
      bb_out_r <= 4'h0;
      bb_wr_n_r <= 1'b1;
      bb_rd_n_r <= 1'b1;
      bb_samp_r <= 1'b0;
      bb_in_r <= 4'h0;
    end else begin
      if (tick16_r) begin
        bb_sub_r <= bb_sub_r + 4'h1;
      end
      if (bb_step) begin
        bb_out_r <= out_head[3:0];
      end
      bb_wr_n_r <= ~bb_step;
      bb_rd_n_r <= ~((bb_step & sync_bb) | (rd_pins & ~uart_mode));
      bb_samp_r <= bb_step & sync_bb;
      if (bb_step) begin
        bb_in_r <= pin_s2_r;
      end
    end
  end

  assign out_pop = tx_load | bb_step;
  assign in_push = rx_push_r | bb_samp_r;
  assign in_wdata = bb_samp_r ? {4'h0, bb_in_r} : rx_byte_r;

  // ==========================================================
  // Pin drive and configurable pin selection
  wire rts_ready = (in_cnt < ubu_pkg::RTS_LIMIT) |
    (flow != ubu_pkg::FLOW_RTSCTS);
  wire txd_level = (tx_line & ~brk_cmd) ^ inv[0];
  wire rts_level = ~rts_ready ^ inv[2];
  wire [3:0] uart_o = {1'b0, rts_level, 1'b0, txd_level};
  wire [3:0] pin_o_nxt = uart_mode ? uart_o : bb_out_r;
  wire [3:0] pin_oe_nxt = uart_mode ? 4'b0101 : bb_dir;
  wire drv_en = tx_busy | brk_cmd;
  wire run_clk = ~suspend_i;
  wire cfg_o_nxt =
    (pin_func == ubu_pkg::PIN_DRIVE1) ? 1'b1 :
    (pin_func == ubu_pkg::PIN_DRIVER_EN) ? drv_en :
    (pin_func == ubu_pkg::PIN_SLEEP_N) ? ~suspend_i :
    (pin_func == ubu_pkg::PIN_CLK24) ?
      run_clk & ref_acc_r[ubu_pkg::REF_BIT_24M] :
    (pin_func == ubu_pkg::PIN_CLK12) ?
      run_clk & ref_acc_r[ubu_pkg::REF_BIT_12M] :
    (pin_func == ubu_pkg::PIN_CLK6) ?
      run_clk & ref_acc_r[ubu_pkg::REF_BIT_6M] :
    (pin_func == ubu_pkg::PIN_BB_WR_N) ? bb_wr_n_r :
    (pin_func == ubu_pkg::PIN_BB_RD_N) ? bb_rd_n_r : 1'b0;
  wire cfg_oe_nxt = (pin_func != ubu_pkg::PIN_TRISTATE) &
    (pin_func <= ubu_pkg::PIN_BB_RD_N);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ser_pin_o <= 4'h0;
      ser_pin_oe_o <= 4'h0;
      config_pin_o <= 1'b0;
      config_pin_oe_o <= 1'b0;
    end else begin
      ser_pin_o <= pin_o_nxt;
      ser_pin_oe_o <= pin_oe_nxt;
      config_pin_o <= cfg_o_nxt;
      config_pin_oe_o <= cfg_oe_nxt;
    end
  end

  // ==========================================================
  // Register file and read mux
  wire [3:0] sticky_set = {in_push & in_full, rx_perr, rx_ferr, rx_brk};
  wire [3:0] sticky_clr = {4{wr_status}} & wbits[3:0];
  wire [31:0] status_word = {23'h0, in_empty, out_full, tx_busy,
                             cts_ok, paused_r, sticky_r};
  wire [31:0] rd_mux =
    (addr == ubu_pkg::REG_CTRL) ? {16'h0, ctrl_r} :
    (addr == ubu_pkg::REG_BAUD) ? {15'h0, baud_r} :
    (addr == ubu_pkg::REG_NVCFG) ? {24'h0, nvcfg_r} :
    (addr == ubu_pkg::REG_DATA) ? {23'h0, ~in_empty, in_head} :
    (addr == ubu_pkg::REG_STATUS) ? status_word :
    (addr == ubu_pkg::REG_LEVEL) ? {6'h0, in_cnt, 6'h0, out_cnt} :
    (addr == ubu_pkg::REG_PINS) ? {28'h0, pin_s2_r} : 32'h0;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= ubu_pkg::CTRL_RST;
      baud_r <= ubu_pkg::BAUD_RST;
      nvcfg_r <= ubu_pkg::NVCFG_RST;
      sticky_r <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= (ctrl_r & ~wmask[15:0]) | wbits[15:0];
      end
      if (wr_baud) begin
        baud_r <= (baud_r & ~wmask[16:0]) | wbits[16:0];
      end
      if (wr_nvcfg) begin
        nvcfg_r <= (nvcfg_r & ~wmask[7:0]) | wbits[7:0];
      end
      sticky_r <= (sticky_r & ~sticky_clr) | sticky_set;
    end
  end

  // One wait state, read data captured as waitrequest falls
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_r <= 1'b1;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      wait_r <= ~(req & wait_r);
      avs_waitrequest_o <= ~(req & wait_r);
      if (avs_read_i && wait_r) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end
endmodule

/* File: hw/ubu_pkg.sv */
// Shared constants and types for the USB serial UART bit-bang core
package ubu_pkg;
  // ==========================================================
  // Clocking and baud generation
  localparam longint CLK_HZ = 20_000_000;
  localparam longint REF_HZ = 48_000_000;
  localparam longint BAUD_GCD = 4_000_000;
  localparam int FRAC_STEPS = 8;
  localparam logic [21:0] BAUD_INC =
    22'(REF_HZ * FRAC_STEPS / BAUD_GCD);
  localparam logic [2:0] BAUD_SCALE = 3'(CLK_HZ / BAUD_GCD);
  localparam logic [18:0] REF_PHASE_INC =
    19'(64'd48_000_000 * 64'd65536 / 64'd20_000_000);
  localparam int REF_BIT_24M = 16;
  localparam int REF_BIT_12M = 17;
  localparam int REF_BIT_6M = 18;
  localparam logic [13:0] BAUD_N_MAX_CODE = 14'h0000;
  localparam logic [14:0] BAUD_N_MAX = 15'h4000;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] SUB_MID = 4'h7;

  // ==========================================================
  // Register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_BAUD = 5'h04;
  localparam logic [4:0] REG_NVCFG = 5'h08;
  localparam logic [4:0] REG_DATA = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_LEVEL = 5'h14;
  localparam logic [4:0] REG_PINS = 5'h18;

  // ==========================================================
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DATA8 = 2;
  localparam int CTRL_PAR_LSB = 3;
  localparam int CTRL_STOP2 = 6;
  localparam int CTRL_FLOW_LSB = 7;
  localparam int CTRL_BREAK = 9;
  localparam int CTRL_DIR_LSB = 12;
  localparam int BAUD_FRAC_LSB = 14;
  localparam int NVCFG_INV_LSB = 4;
  localparam int DATA_VALID = 8;
  localparam int ST_PAUSED = 4;
  localparam int ST_CTS_OK = 5;
  localparam int ST_TX_BUSY = 6;
  localparam int ST_OUT_FULL = 7;
  localparam int ST_IN_EMPTY = 8;
  localparam int LEVEL_IN_LSB = 16;

  // ==========================================================
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0004;
  localparam logic [16:0] BAUD_RST = 17'h00138;
  localparam logic [7:0] NVCFG_RST = 8'h03;

  // ==========================================================
  // Encodings
  localparam logic [1:0] MODE_UART = 2'h0;
  localparam logic [1:0] MODE_BB_ASYNC = 2'h1;
  localparam logic [1:0] MODE_BB_SYNC = 2'h2;
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_EVEN = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [1:0] FLOW_RTSCTS = 2'h1;
  localparam logic [1:0] FLOW_XONXOFF = 2'h2;
  localparam logic [7:0] CHAR_XON = 8'h11;
  localparam logic [7:0] CHAR_XOFF = 8'h13;
  localparam logic [9:0] RTS_LIMIT = 10'h1E0;
  localparam logic [3:0] PIN_TRISTATE = 4'h0;
  localparam logic [3:0] PIN_DRIVE1 = 4'h1;
  localparam logic [3:0] PIN_DRIVE0 = 4'h2;
  localparam logic [3:0] PIN_DRIVER_EN = 4'h3;
  localparam logic [3:0] PIN_SLEEP_N = 4'h4;
  localparam logic [3:0] PIN_CLK24 = 4'h5;
  localparam logic [3:0] PIN_CLK12 = 4'h6;
  localparam logic [3:0] PIN_CLK6 = 4'h7;
  localparam logic [3:0] PIN_BB_WR_N = 4'h8;
  localparam logic [3:0] PIN_BB_RD_N = 4'h9;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
  } ubu_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT
  } ubu_rx_e;
endpackage

/* File: verif/tb_top.sv */
// Self-checking bench of the serial core
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, rst_b = 0, rd = 0, wr = 0, susp = 0, hold = 0;
  logic wq, cfg, cfg_oe;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0, rdata, got;
  logic [3:0] pin_i, pin_o, pin_oe;
  int mismatches = 0, comparisons = 0, cyc = 0, n;
  initial forever #25 clk = ~clk;
  ubu_core ubu_core_inst (.core_clk_i(clk), .rst_b_i(rst_b),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wq), .ser_pin_i(pin_i),
    .ser_pin_o(pin_o), .ser_pin_oe_o(pin_oe), .config_pin_o(cfg),
    .config_pin_oe_o(cfg_oe), .suspend_i(susp));
  ubu_peer ubu_peer_inst (.pin_o_i(pin_o), .pin_oe_i(pin_oe),
    .cts_hold_i(hold), .line_o(pin_i));
  // ========================
  // Tasks
  task results;
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wq !== 1'b0);
    got = rdata;
    rd <= 0;
    wr <= 0;
  endtask
  task rchk(input logic [4:0] a, input logic [31:0] e);
    acc(0, a, 32'h0);
    chk(got, e);
  endtask
  // Samples ten bit times from the start edge, each mid bit
  task frame(input logic [9:0] e);
    logic [9:0] f;
    while (pin_o[0] !== 1'b0) @(posedge clk);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      f[i] = pin_o[0];
      repeat (16) @(posedge clk);
    end
    chk(32'(f), 32'(e));
    repeat (40) @(posedge clk);
  endtask
  task highs;
    n = 0;
    repeat (40) @(posedge clk) n += int'(cfg);
  endtask
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      results;
    end
  end
  // ========================
  // Sequence of tests
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1;
    rchk(5'h00, 32'h0004);
    rchk(5'h04, 32'h0138);
    rchk(5'h08, 32'h0003);
    rchk(5'h1C, 32'h0);
    hold <= 1;
    acc(1, 5'h04, 32'h2);
    acc(1, 5'h00, 32'h0084);
    acc(1, 5'h0C, 32'hA5);
    repeat (300) @(posedge clk);
    chk(32'(pin_o[0]), 32'h1);
    rchk(5'h14, 32'h1);
    hold <= 0;
    frame({1'b1, 8'hA5, 1'b0});
    rchk(5'h0C, 32'h1A5);
    for (int p = 1; p < 5; p++) begin
      acc(1, 5'h00, 32'(4 + p * 8));
      acc(1, 5'h0C, 32'hA5);
      frame({p[0], 8'hA5, 1'b0});
      rchk(5'h0C, 32'h1A5);
    end
    acc(1, 5'h00, 32'h0);
    acc(1, 5'h0C, 32'hA5);
    frame({2'b11, 7'h25, 1'b0});
    rchk(5'h0C, 32'h125);
    acc(0, 5'h0C, 32'h0);
    chk(32'(got[8]), 32'h0);
    acc(1, 5'h08, 32'h1);
    acc(1, 5'h00, 32'h0204);
    repeat (400) @(posedge clk);
    chk(32'({cfg_oe, cfg, pin_o[0]}), 32'h6);
    acc(1, 5'h00, 32'h0004);
    repeat (40) @(posedge clk);
    acc(0, 5'h10, 32'h0);
    chk(32'(got[0]), 32'h1);
    acc(1, 5'h10, 32'hF);
    acc(0, 5'h10, 32'h0);
    chk(got & 32'hF, 32'h0);
    acc(1, 5'h08, 32'h83);
    acc(0, 5'h10, 32'h0);
    chk(32'(got[5]), 32'h0);
    acc(1, 5'h08, 32'h6);
    susp <= 1;
    repeat (4) @(posedge clk);
    highs;
    chk(32'(n), 32'h0);
    susp <= 0;
    repeat (4) @(posedge clk);
    highs;
    chk(32'(n > 0), 32'h1);
    acc(1, 5'h08, 32'h8);
    acc(1, 5'h00, 32'hF001);
    acc(1, 5'h0C, 32'h3);
    acc(1, 5'h0C, 32'hC);
    while (pin_o !== 4'h3) @(posedge clk);
    repeat (8) @(posedge clk);
    chk(32'({pin_oe, pin_o}), 32'hF3);
    repeat (16) @(posedge clk);
    chk(32'(pin_o), 32'hC);
    acc(1, 5'h08, 32'h9);
    rchk(5'h18, 32'hC);
    acc(1, 5'h00, 32'h3002);
    acc(1, 5'h0C, 32'h5);
    acc(1, 5'h0C, 32'h6);
    repeat (60) @(posedge clk);
    acc(0, 5'h0C, 32'h0);
    rchk(5'h0C, 32'h105);
    acc(1, 5'h00, 32'h0004);
    results;
  end
endmodule

/* File: verif/ubu_core_monitor.sv */
// Checker of bus handshake, line and pin timing of the serial core
`timescale 1ns/100ps
// ========================
// Checker
module ubu_core_monitor (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [3:0] ser_pin_o,
  input wire logic [3:0] ser_pin_oe_o,
  input wire logic config_pin_o
);
  wire uart_w = ser_pin_oe_o == 4'h5;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Pending request and start of a character
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_start;
    $fell(ser_pin_o[0]) && uart_w;
  endsequence
  property p_ans; s_req |=> !avs_waitrequest_o; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_one: assert property (p_one) else $error("wait low long");
  property p_cause;
    $fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i);
  endproperty
  a_cause: assert property (p_cause) else $error("stray answer");
  property p_hold; !avs_read_i |=> $stable(avs_readdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rst;
    $rose(rst_b_i) |=> uart_w && ser_pin_o[0] && !ser_pin_o[2];
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset lines");
  property p_start; s_start |=> !ser_pin_o[0] [*8]; endproperty
  a_start: assert property (p_start) else $error("short start");
  property p_den; s_start |-> ##[0:2] config_pin_o; endproperty
  a_den: assert property (p_den) else $error("no driver enable");
  property p_strobe;
    $fell(config_pin_o) && !uart_w |=> config_pin_o;
  endproperty
  a_strobe: assert property (p_strobe) else $error("long strobe");
  property p_rts; uart_w |-> !ser_pin_o[2]; endproperty
  a_rts: assert property (p_rts) else $error("rts dropped");
endmodule
bind ubu_core ubu_core_monitor ubu_core_monitor_inst (.core_clk_i,
  .rst_b_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .ser_pin_o, .ser_pin_oe_o, .config_pin_o);

/* File: verif/ubu_peer.sv */
// Serial peer: loops transmit back to receive and drives clear to send
`timescale 1ns/100ps
module ubu_peer (
  input wire logic [3:0] pin_o_i,
  input wire logic [3:0] pin_oe_i,
  input wire logic cts_hold_i,
  output logic [3:0] line_o
);
  logic txd_w;
  logic [3:0] peer_w;
  // Peer levels; cts stays low unless the bench stalls the peer
  assign txd_w = pin_oe_i[0] ? pin_o_i[0] : 1'b1;
  assign peer_w = {cts_hold_i, 1'b1, txd_w, 1'b1};
  // Each line takes the level of whichever side enables it
  assign line_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & peer_w);
endmodule
